//--- include/ifrx_pkg.sv
package ifrx_pkg;
    // ========================================================
    // register map (byte address = index * 4)
    localparam logic [3:0]  IDX_LOOP_CTRL   = 4'h7;
    localparam logic [3:0]  IDX_STAGE_GAIN  = 4'h8;
    localparam logic [3:0]  IDX_RESET_KEY   = 4'h9;
    localparam logic [3:0]  IDX_POWER_MODE  = 4'hA;
    localparam logic [3:0]  IDX_GAIN_RDBK   = 4'hB;
    localparam int          REG_W           = 18;
    // ========================================================
    // loop control fields
    localparam int F_HOLD      = 17;
    localparam int F_UTH       = 14;
    localparam int F_LTH       = 11;
    localparam int F_CAL       = 10;
    localparam int F_FAST      = 9;
    localparam int F_TIME      = 7;
    localparam int F_STEP1     = 6;
    localparam int F_DIS       = 5;
    localparam int F_BPF       = 2;
    localparam int F_LOF       = 0;
    localparam logic [17:0] LOOP_CTRL_RST = 18'h162CC;
    // stage gain fields
    localparam int F_MIXG      = 15;
    localparam int F_LOWG      = 14;
    localparam int F_MAN2      = 9;
    localparam int F_MAN1      = 3;
    localparam int F_OBG       = 0;
    localparam logic [17:0] STAGE_GAIN_RST = 18'h18001;
    // power mode fields
    localparam int F_HSRC      = 14;
    localparam int F_DEMOD     = 9;
    localparam int F_BS        = 4;
    localparam logic [17:0] POWER_MODE_RST = 18'h00220;
    // ========================================================
    // reset key and gain limits
    localparam logic [7:0]  RESET_KEY_VAL  = 8'hAA;
    localparam logic signed [5:0] G1_MIN   = -6'sd19;
    localparam logic signed [5:0] G1_MAX   = 6'sd21;
    localparam logic [4:0]  G2_MAX         = 5'd12;
    // ========================================================
    // timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int CAL_TIME_US   = 1300;
    localparam int CAL_CYCLES    = CAL_TIME_US * (CLK_HZ / 1_000_000);
    localparam int STEP_BASE_CYC = 1000;
    typedef enum logic [1:0] {IFRX_LS_A, IFRX_LS_B, IFRX_LS_C, IFRX_LS_CONV} ifrx_lstate_t;
endpackage

//--- hw/ifrx_regs.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: gain hold freezes both stage gains while loop active.
// RULE_02: upper threshold code 0..7 means -5..+2 dB, default 101.
// RULE_03: lower threshold code maps -8,-6,-4,-2,0,1,2,3 dB, default 100.
// RULE_04: above upper threshold gain drops, below lower threshold gain rises.
// RULE_05: disable bit 0 runs the loop, 1 stops it.
// RULE_06: rising edge of calibration bit starts 1.3 ms calibration, self-clears.
// RULE_07: adaptive speed uses code-00 interval for attack and release.
// RULE_08: step interval field sets time per one-step gain change.
// RULE_09: loop state A, B or C from stage levels against thresholds.
// RULE_10: first-stage step size 1 or 2 dB, default 2 dB.
// RULE_11: bandpass top bit selects F0, else F1..F4.
// RULE_12: local frequency code selects 45.9, 50.4, 57.6, 28.8 MHz.
// RULE_13: mixer gain code maps 42..56 dB in 2 dB steps.
// RULE_14: low-gain override fixes mixer gain at 28 dB.
// RULE_15: manual second-stage gain 0..12 dB used when loop disabled.
// RULE_16: manual first-stage gain -19..21 dB used when loop disabled.
// RULE_17: output buffer gain 0..15 dB in 3 dB steps, default 001.
// RULE_18: writing 0xAA to reset key triggers software reset.
// RULE_19: power pin low turns all off; block select enables cumulatively. Code 6 here leaves bit 4 off, although code 5 enables it.
// RULE_20: host never programs mode 1 or code 000 while powered.
// RULE_21: demod level codes map to 100,200,300,50,100,150 mVrms.
// RULE_22: current loop gain codes readable while loop enabled.
// RULE_23: hold source select picks register bit or hold pin.
// RULE_24: loop saturates gains at -19..21 and 0..12 dB.
// RULE_25: calibration bit reads one while calibration runs.
module ifrx_regs
    import ifrx_pkg::*;
#(
    parameter int CAL_CYC  = CAL_CYCLES,
    parameter int STEP_CYC = STEP_BASE_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic        power_down_pin_n,
    input  wire logic        gain_hold_pin,
    // level detector inputs from analog stages
    input  wire logic        stage1_above_upper,
    input  wire logic        stage1_below_lower,
    input  wire logic        stage2_above_upper,
    input  wire logic        stage2_below_lower,
    // analog controls
    output logic signed [5:0] first_stage_gain,
    output logic [4:0]       second_stage_gain,
    output logic [2:0]       loop_upper_threshold,
    output logic [2:0]       loop_lower_threshold,
    output logic [2:0]       bandpass_width_sel,
    output logic [2:0]       bandpass_filter_id,
    output logic [1:0]       local_freq_sel,
    output logic [5:0]       mixer_gain_db,
    output logic [3:0]       output_buffer_gain_db,
    output logic [2:0]       demod_output_level,
    output logic [6:0]       subblock_enable,
    output logic             cal_active,
    output logic             soft_reset
);
    // ========================================================
    // synchronisers for pins and analog comparators
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else if (clk_en) begin
            sync1_q <= {power_down_pin_n, gain_hold_pin, stage1_above_upper,
                        stage1_below_lower, stage2_above_upper, stage2_below_lower};
            sync2_q <= sync1_q;
        end
    end
    wire pdn_s  = sync2_q[5];
    wire hpin_s = sync2_q[4];
    wire s1_hi  = sync2_q[3];
    wire s1_lo  = sync2_q[2];
    wire s2_hi  = sync2_q[1];
    wire s2_lo  = sync2_q[0];

    // ========================================================
    // ahb address phase capture
    logic       wr_pend_q;
    logic [3:0] wr_idx_q;
    logic [31:0] rdata_q;
    wire        acc      = hsel && hready && htrans[1];
    wire [3:0]  acc_idx  = haddr[5:2];
    wire        wr_loop  = wr_pend_q && (wr_idx_q == IDX_LOOP_CTRL);
    wire        wr_gain  = wr_pend_q && (wr_idx_q == IDX_STAGE_GAIN);
    wire        wr_key   = wr_pend_q && (wr_idx_q == IDX_RESET_KEY);
    wire        wr_pwr   = wr_pend_q && (wr_idx_q == IDX_POWER_MODE);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // ========================================================
    // register storage
    logic [17:0] loop_q;
    logic [17:0] gain_q;
    logic [17:0] pwr_q;
    logic        cal_q;
    logic        reset_key_q;
    logic [21:0] cal_cnt_q;
    logic        cal_req_prev_q;
    wire         cal_wr_bit = hwdata[F_CAL];
    wire         cal_start  = wr_loop && cal_wr_bit && !cal_req_prev_q; // RULE_06
    wire         cal_done   = cal_q && (cal_cnt_q == 22'(CAL_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 4'h0;
            loop_q    <= LOOP_CTRL_RST;
            gain_q    <= STAGE_GAIN_RST;
            pwr_q     <= POWER_MODE_RST;
        end else if (clk_en) begin
            wr_pend_q <= acc && hwrite;
            wr_idx_q  <= acc_idx;
            if (reset_key_q) begin // RULE_18
                loop_q <= LOOP_CTRL_RST;
                gain_q <= STAGE_GAIN_RST;
                pwr_q  <= POWER_MODE_RST;
            end else begin
                if (wr_loop) loop_q <= hwdata[17:0];
                if (wr_gain) gain_q <= hwdata[17:0];
                if (wr_pwr)  pwr_q  <= hwdata[17:0];
            end
        end
    end

    // calibration sequencer, bit reads one until done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_q          <= 1'b0;
            cal_cnt_q      <= 22'h0;
            cal_req_prev_q <= 1'b0;
            reset_key_q         <= 1'b0;
        end else if (clk_en) begin
            if (wr_loop) cal_req_prev_q <= cal_wr_bit;
            else if (cal_done) cal_req_prev_q <= 1'b0;
            reset_key_q <= wr_key && (hwdata[7:0] == RESET_KEY_VAL); // RULE_18
            if (reset_key_q) begin
                cal_q     <= 1'b0;
                cal_cnt_q <= 22'h0;
            end else if (cal_start) begin // RULE_06
                cal_q     <= 1'b1;
                cal_cnt_q <= 22'h0;
            end else if (cal_done) begin
                cal_q <= 1'b0; // RULE_06
            end else if (cal_q) begin
                cal_cnt_q <= cal_cnt_q + 22'h1;
            end
        end
    end
    assign cal_active = cal_q;
    assign soft_reset = reset_key_q;

    // ========================================================
    // field decode
    wire       loop_off  = loop_q[F_DIS]; // RULE_05
    wire       hold      = pwr_q[F_HSRC] ? hpin_s : loop_q[F_HOLD]; // RULE_23
    wire       fast      = loop_q[F_FAST];
    wire [1:0] tcode     = loop_q[F_TIME +: 2];
    wire       step2     = loop_q[F_STEP1]; // RULE_10
    assign loop_upper_threshold = loop_q[F_UTH +: 3]; // RULE_02
    assign loop_lower_threshold = loop_q[F_LTH +: 3]; // RULE_03
    assign bandpass_width_sel   = loop_q[F_BPF +: 3];
    // F0 = 0, F1..F4 = 1..4
    assign bandpass_filter_id   = bandpass_width_sel[2] ? 3'd0
                                  : {1'b0, bandpass_width_sel[1:0]} + 3'd1; // RULE_11
    assign local_freq_sel       = loop_q[F_LOF +: 2]; // RULE_12
    wire [2:0] mix_code  = gain_q[F_MIXG +: 3];
    assign mixer_gain_db = gain_q[F_LOWG] ? 6'd28 // RULE_14
                           : 6'd42 + {2'b00, mix_code, 1'b0}; // RULE_13
    wire [2:0] obg_code  = gain_q[F_OBG +: 3];
    assign output_buffer_gain_db = 4'({obg_code, 1'b0} + {1'b0, obg_code}); // RULE_17
    assign demod_output_level    = pwr_q[F_DEMOD +: 3]; // RULE_21

    // power modes: LDOD, LDOA, LOBUF, MIX, IFBUF, LIMITER, DISCRI
    wire [2:0] bs = pwr_q[F_BS +: 3];
    always_comb begin
        subblock_enable = 7'h00;
        if (pdn_s) begin // RULE_19
            unique case (bs)
                3'd1:    subblock_enable = 7'b0000001;
                3'd2:    subblock_enable = 7'b0000011;
                3'd3:    subblock_enable = 7'b0000111;
                3'd4:    subblock_enable = 7'b0011111;
                3'd5:    subblock_enable = 7'b0111111;
                3'd6:    subblock_enable = 7'b1101111;
                3'd7:    subblock_enable = 7'b1111111;
                default: subblock_enable = 7'h00; // RULE_20
            endcase
        end
    end

    // ========================================================
    // gain loop state classification
    ifrx_lstate_t lstate;
    always_comb begin
        if (s1_hi)      lstate = IFRX_LS_A; // RULE_09
        else if (s2_hi) lstate = IFRX_LS_B;
        else if (s2_lo) lstate = IFRX_LS_C;
        else            lstate = IFRX_LS_CONV;
    end
    wire conv = (lstate == IFRX_LS_CONV) && !s1_lo;
    // interval quadruples per code; code 00 during attack/release when fast
    wire [1:0] eff_code = (fast && !conv) ? 2'b00 : tcode; // RULE_07
    wire [31:0] step_lim = (32'(STEP_CYC) << {eff_code, 1'b0}) - 32'h1; // RULE_08
    logic [31:0] step_cnt_q;
    wire step_tick = (step_cnt_q >= step_lim);

    logic signed [5:0] g1_q;
    logic [4:0]        g2_q;
    wire signed [6:0] g1_dn  = 7'(g1_q) - (step2 ? 7'sd2 : 7'sd1);
    wire signed [6:0] g1_up  = 7'(g1_q) + (step2 ? 7'sd2 : 7'sd1);
    // saturate at table limits
    wire signed [5:0] g1_dn_s = (g1_dn < 7'(G1_MIN)) ? G1_MIN : 6'(g1_dn); // RULE_24
    wire signed [5:0] g1_up_s = (g1_up > 7'(G1_MAX)) ? G1_MAX : 6'(g1_up); // RULE_24
    wire loop_run = !loop_off && !hold; // RULE_01
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            g1_q       <= 6'sd0;
            g2_q       <= 5'd0;
            step_cnt_q <= 32'h0;
        end else if (clk_en) begin
            if (!loop_run || step_tick) step_cnt_q <= 32'h0;
            else step_cnt_q <= step_cnt_q + 32'h1;
            if (loop_run && step_tick) begin // RULE_04
                if (s1_hi)                          g1_q <= g1_dn_s;
                else if (s2_hi && g2_q != 5'd0)     g2_q <= g2_q - 5'd1;
                else if (s2_lo && g2_q != G2_MAX)   g2_q <= g2_q + 5'd1; // RULE_24
                else if (s1_lo)                     g1_q <= g1_up_s;
            end
        end
    end
    // manual codes drive the stages when the loop is off
    assign first_stage_gain  = loop_off ? $signed(gain_q[F_MAN1 +: 6]) : g1_q; // RULE_16
    assign second_stage_gain = loop_off ? gain_q[F_MAN2 +: 5] : g2_q; // RULE_15

    // ========================================================
    // read data mux; reset key reads zero
    logic [17:0] rd_mux;
    always_comb begin
        unique case (acc_idx)
            IDX_LOOP_CTRL:  rd_mux = {loop_q[17:11], cal_q, loop_q[9:0]}; // RULE_25
            IDX_STAGE_GAIN: rd_mux = gain_q;
            IDX_POWER_MODE: rd_mux = pwr_q;
            IDX_GAIN_RDBK:  rd_mux = loop_off ? 18'h0 : {7'h0, g1_q, g2_q}; // RULE_22
            default:        rd_mux = 18'h0;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rdata_q <= 32'h0;
        else if (clk_en && acc && !hwrite) rdata_q <= {14'h0, rd_mux};
    end
endmodule

//--- bench/ifrx_regs_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the receiver register bank
module ifrx_regs_monitor
    import ifrx_pkg::*;
#(
    parameter int CAL_CYC = CAL_CYCLES
) (
    // clock and reset
    input wire logic              hclk,
    input wire logic              hresetn,
    // bus answer
    input wire logic              hreadyout,
    input wire logic              hresp,
    // controls
    input wire logic              power_down_pin_n,
    input wire logic signed [5:0] first_stage_gain,
    input wire logic [4:0]        second_stage_gain,
    input wire logic [2:0]        bandpass_width_sel,
    input wire logic [2:0]        bandpass_filter_id,
    input wire logic [5:0]        mixer_gain_db,
    input wire logic [3:0]        output_buffer_gain_db,
    input wire logic [6:0]        subblock_enable,
    input wire logic              cal_active,
    input wire logic              soft_reset
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] cal_cnt_q;
    // length of the running calibration, zero when idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_cnt_q <= 32'h0;
        end else begin
            cal_cnt_q <= cal_active ? cal_cnt_q + 32'h1 : 32'h0;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_reset_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset longer than one cycle");
    a_mixer_range: assert property (mixer_gain_db == 6'h1C ||
        (mixer_gain_db >= 6'h2A && mixer_gain_db <= 6'h38 && !mixer_gain_db[0]))
        else $error("mixer gain off its table");
    a_obuf_steps: assert property (output_buffer_gain_db <= 4'hF &&
        output_buffer_gain_db % 3 == 0) else $error("buffer gain off its table");
    a_bpf_decode: assert property (bandpass_filter_id == (bandpass_width_sel[2] ?
        3'h0 : {1'b0, bandpass_width_sel[1:0]} + 3'h1)) else $error("filter decode wrong");
    a_gain_limits: assert property (first_stage_gain >= G1_MIN &&
        first_stage_gain <= G1_MAX && second_stage_gain <= G2_MAX)
        else $error("stage gain beyond limits");
    a_power_off: assert property (!power_down_pin_n [*4] |-> subblock_enable == 7'h00)
        else $error("blocks on while powered down");
    a_blocks_cumul: assert property (|subblock_enable[6:3] |->
        subblock_enable[2:0] == 3'h7) else $error("block enables not cumulative");
    a_cal_bound: assert property (cal_active |-> cal_cnt_q < 32'(CAL_CYC))
        else $error("calibration overruns");
    a_cal_length: assert property ($fell(cal_active) |->
        $past(cal_cnt_q) == 32'(CAL_CYC - 1)) else $error("calibration length wrong");
endmodule
bind ifrx_regs ifrx_regs_monitor #(.CAL_CYC(CAL_CYC)) u_mon (.hclk, .hresetn,
    .hreadyout, .hresp, .power_down_pin_n, .first_stage_gain, .second_stage_gain,
    .bandpass_width_sel, .bandpass_filter_id, .mixer_gain_db, .output_buffer_gain_db,
    .subblock_enable, .cal_active, .soft_reset);

//--- bench/ifrx_stage_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog stages with their level detectors
module ifrx_stage_model (
    // input level and loop gains
    input  wire logic signed [7:0] input_level,
    input  wire logic signed [5:0] first_stage_gain,
    input  wire logic [4:0]        second_stage_gain,
    // detector flags
    output logic                   stage1_above_upper,
    output logic                   stage1_below_lower,
    output logic                   stage2_above_upper,
    output logic                   stage2_below_lower
);
    logic signed [8:0] s1_lvl;
    logic signed [8:0] s2_lvl;
    // each tap sees the input plus all gain ahead of it
    assign s1_lvl = 9'(input_level) + 9'(first_stage_gain);
    assign s2_lvl = s1_lvl + 9'({1'b0, second_stage_gain});
    // fixed windows, so a big input pins both flags
    assign stage1_above_upper = s1_lvl > 9'sh00A;
    assign stage1_below_lower = s1_lvl < 9'sh000;
    assign stage2_above_upper = s2_lvl > 9'sh014;
    assign stage2_below_lower = s2_lvl < 9'sh00A;
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the receiver register bank
module tb_top import ifrx_pkg::*;;
    localparam int CAL = 20;
    localparam logic [6:0] SUB_TBL [8] = '{7'h00, 7'h00, 7'h03, 7'h07, 7'h1F, 7'h3F,
        7'h6F, 7'h7F};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic power_down_pin_n = 1'b1, gain_hold_pin = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic signed [7:0] lvl = 8'h00;
    logic hreadyout, hresp, cal_active, soft_reset;
    logic stage1_above_upper, stage1_below_lower, stage2_above_upper, stage2_below_lower;
    logic signed [5:0] first_stage_gain;
    logic [4:0] second_stage_gain;
    logic [2:0] loop_upper_threshold, loop_lower_threshold, bandpass_width_sel;
    logic [2:0] bandpass_filter_id, demod_output_level;
    logic [1:0] local_freq_sel;
    logic [5:0] mixer_gain_db;
    logic [3:0] output_buffer_gain_db;
    logic [6:0] subblock_enable;
    int miscompares = 0, compares = 0, sr_cnt = 0;
    ifrx_regs #(.CAL_CYC(CAL), .STEP_CYC(4)) u_dut (.hclk, .hresetn, .clk_en(1'b1),
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .power_down_pin_n, .gain_hold_pin,
        .stage1_above_upper, .stage1_below_lower, .stage2_above_upper,
        .stage2_below_lower, .first_stage_gain, .second_stage_gain,
        .loop_upper_threshold, .loop_lower_threshold, .bandpass_width_sel,
        .bandpass_filter_id, .local_freq_sel, .mixer_gain_db, .output_buffer_gain_db,
        .demod_output_level, .subblock_enable, .cal_active, .soft_reset);
    ifrx_stage_model u_stage (.input_level(lvl), .first_stage_gain, .second_stage_gain,
        .stage1_above_upper, .stage1_below_lower, .stage2_above_upper,
        .stage2_below_lower);
    // clock and soft reset pulse counter
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (soft_reset === 1'b1) sr_cnt++;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // one single transfer; hready is sampled, never assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic t_reset();
        xfer(0, 8'h1C, 0);
        chk("ctrl", 32'h16240, rd & 32'h3FE60);
        chk("lth", 32'h4, loop_lower_threshold);
        xfer(0, 8'h20, 0);
        chk("gain", 32'h18001, rd & 32'h3C007);
        xfer(0, 8'h28, 0);
        chk("pwr", 32'h20, rd & 32'h4070);
        chk("sub", 32'h3, subblock_enable);
        xfer(0, 8'h30, 0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic t_decode();
        for (int c = 0; c < 8; c++) begin
            xfer(1, 8'h1C, 32'h16260 | (c << 2) | (c & 3));
            xfer(1, 8'h20, (c << 15) | (c % 6));
            chk("bpf", c > 3 ? 0 : c + 1, bandpass_filter_id);
            chk("lof", c & 3, local_freq_sel);
            chk("mix", 42 + 2 * c, mixer_gain_db);
            chk("obuf", 3 * (c % 6), output_buffer_gain_db);
        end
        xfer(1, 8'h20, 32'h4000);
        chk("lowg", 32'h1C, mixer_gain_db);
    endtask
    // loop disabled: a loud input must not move the manual gains
    task automatic t_manual();
        lvl <= 8'h64;
        xfer(1, 8'h20, 32'h1968);
        repeat (50) @(posedge hclk);
        chk("g1", G1_MIN, first_stage_gain);
        chk("g2", G2_MAX, second_stage_gain);
        xfer(1, 8'h20, 32'h18A8);
        chk("g1", G1_MAX, first_stage_gain);
        xfer(0, 8'h2C, 0);
        chk("rdbk", 32'h0, rd);
    endtask
    task automatic t_loop();
        xfer(1, 8'h1C, 32'h16240);
        repeat (300) @(posedge hclk);
        chk("g1", G1_MIN, first_stage_gain);
        lvl <= 8'h9C;
        repeat (400) @(posedge hclk);
        chk("g1", G1_MAX, first_stage_gain);
        chk("g2", G2_MAX, second_stage_gain);
        xfer(0, 8'h2C, 0);
        chk("rdbk", 32'h2AC, rd);
        xfer(1, 8'h1C, 32'h36240);
        lvl <= 8'h64;
        repeat (200) @(posedge hclk);
        chk("g1", G1_MAX, first_stage_gain);
        gain_hold_pin <= 1'b1;
        xfer(1, 8'h28, 32'h4220);
        xfer(1, 8'h1C, 32'h16240);
        repeat (200) @(posedge hclk);
        chk("g1", G1_MAX, first_stage_gain);
        gain_hold_pin <= 1'b0;
        repeat (300) @(posedge hclk);
        chk("g1", G1_MIN, first_stage_gain);
    endtask
    task automatic t_cal();
        xfer(1, 8'h1C, 32'h16640);
        xfer(0, 8'h1C, 0);
        chk("cal", 32'h1, rd[10]);
        repeat (CAL) @(posedge hclk);
        xfer(0, 8'h1C, 0);
        chk("cal", 32'h0, rd[10]);
        chk("cal_active", 32'h0, cal_active);
    endtask
    task automatic t_key();
        xfer(1, 8'h20, 0);
        xfer(1, 8'h24, 32'h55);
        chk("resets", 32'h0, sr_cnt);
        xfer(1, 8'h24, 32'hAA);
        @(posedge hclk);
        chk("resets", 32'h1, sr_cnt);
        xfer(0, 8'h20, 0);
        chk("gain", 32'h18001, rd & 32'h3C007);
    endtask
    task automatic t_power();
        for (int m = 2; m < 8; m++) begin
            xfer(1, 8'h28, ((m == 4 ? 1 : m) << 9) | (m << 4));
            repeat (3) @(posedge hclk);
            chk("sub", SUB_TBL[m], subblock_enable);
            chk("demod", m == 4 ? 1 : m, demod_output_level);
        end
        power_down_pin_n <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("sub", 32'h0, subblock_enable);
    endtask
    task automatic stop_test();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_decode();
        t_manual();
        t_loop();
        t_cal();
        t_key();
        t_power();
        stop_test();
    end
    // hang guard, well beyond the roughly 1,600 cycles needed
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        stop_test();
    end
endmodule
